// *** hw/nmld_cfg.svh ***
`ifndef NMLD_CFG_SVH
`define NMLD_CFG_SVH
// Notes on behaviour
// - Copy bank select into addressed nibble and accumulator in one cycle, zero flag updated.
// - Copy port change flags into addressed nibble and accumulator, zero flag updated.
// - A change flag reads 1 after a change on its wake pin, else 0.
// - Prefix 01111 copies working register to accumulator and nibble, zero flag updated.
// - Prefix 01101 copies nibble to working register and accumulator, zero flag updated.
// - Pointer table fetch takes two cycles and stores the ROM nibble into memory.
// - Prefix 10101 fetches ROM at immediate times 10H plus accumulator into register.
// - Hold release cause bit 2 set when hold ends by a wake pin change.

// ****************************************************************
// Instruction encodings
// ****************************************************************
`define NMLD_OP9_COPY_BANK   9'h0BF
`define NMLD_OP9_COPY_CHG    9'h09E
`define NMLD_OP9_FETCH_PTR   9'h132
`define NMLD_OP5_WR_TO_MEM   5'h0F
`define NMLD_OP5_MEM_TO_WR   5'h0D
`define NMLD_OP5_FETCH_IMM   5'h15

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define NMLD_CAUSE_BIT       2
`define NMLD_NIB_RESET       4'h0
`endif

// *** hw/nmld_pkg.sv ***
package nmld_pkg;
	typedef logic [3:0] nmld_nib_t;
	typedef enum logic {NMLD_IDLE, NMLD_FETCH} nmld_state_t;
	typedef enum logic [2:0] {
		NMLD_K_NONE, NMLD_K_BANK, NMLD_K_CHG, NMLD_K_WR2M,
		NMLD_K_M2WR, NMLD_K_FPTR, NMLD_K_FIMM
	} nmld_kind_t;
endpackage

// *** hw/nmld_change_detect.sv ***
`timescale 1ns/100ps
`include "nmld_cfg.svh"
module nmld_change_detect (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [3:0]  wake,
	input  wire logic        flags_clr,
	input  wire logic        hold_active,
	input  wire logic        cause_clr,
	output logic      [3:0]  flags,
	output logic      [3:0]  cause
);
	logic [3:0] prev_q;
	logic       prev_ok_q;
	logic [3:0] flags_q;
	logic [3:0] cause_q;
	logic [3:0] edge_w;

	// A change only counts once a previous sample exists, so reset never fakes one.
	assign edge_w = prev_ok_q ? (wake ^ prev_q) : 4'h0;

	// ****************************************************************
	// Previous sample of the wake pins.
	// ****************************************************************
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prev_q    <= `NMLD_NIB_RESET;
			prev_ok_q <= 1'b0;
		end
		else if (ce)
		begin
			prev_q    <= wake;
			prev_ok_q <= 1'b1;
		end
	end

	// Sticky change flags; a new change wins over the clear by a read.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			flags_q <= `NMLD_NIB_RESET;
		else if (ce)
			flags_q <= (flags_clr ? 4'h0 : flags_q) | edge_w;
	end

	// Hold release cause, only the wake-port bit is owned here.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cause_q <= `NMLD_NIB_RESET;
		else if (ce)
		begin
			if (hold_active && (edge_w != 4'h0))
				cause_q[`NMLD_CAUSE_BIT] <= 1'b1;
			else if (cause_clr)
				cause_q[`NMLD_CAUSE_BIT] <= 1'b0;
		end
	end

	assign flags = flags_q;
	assign cause = cause_q;

	AST_FLAG_ON_CHANGE: assert property (@(posedge clk) disable iff (!reset_n)
		(ce && prev_ok_q && (wake != prev_q)) |=> ((flags_q & $past(wake ^ prev_q))
		== $past(wake ^ prev_q)))
		else $error("Change flag missed a wake pin change.");
	AST_CAUSE_ON_WAKE: assert property (@(posedge clk) disable iff (!reset_n)
		(ce && hold_active && (edge_w != 4'h0)) |=> cause_q[`NMLD_CAUSE_BIT])
		else $error("Hold release cause not set by wake change.");
endmodule

// *** hw/nmld_top.sv ***
`timescale 1ns/100ps
`include "nmld_cfg.svh"
module nmld_top (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        CE,
	input  wire logic        INSTR_VALID,
	input  wire logic [15:0] INSTR,
	output logic             BUSY,
	input  wire logic [3:0]  BANK_SELECT,
	input  wire logic [3:0]  LOOKUP_PTR_LOW,
	input  wire logic [3:0]  LOOKUP_PTR_HIGH,
	input  wire logic [3:0]  WAKE_PORT,
	input  wire logic        HOLD_ACTIVE,
	input  wire logic        CAUSE_CLR,
	output logic      [3:0]  HOLD_RELEASE_CAUSE,
	output logic      [3:0]  PORT_C_CHANGE_FLAGS,
	output logic      [6:0]  RAM_RADDR,
	input  wire logic [3:0]  RAM_RDATA,
	output logic             RAM_WE,
	output logic      [6:0]  RAM_WADDR,
	output logic      [3:0]  RAM_WDATA,
	output logic      [15:0] ROM_ADDR,
	input  wire logic [3:0]  ROM_DATA,
	output logic      [3:0]  WORKING_SUM,
	output logic             RESULT_ZERO_FLAG
);
	nmld_pkg::nmld_state_t state_q;
	nmld_pkg::nmld_kind_t  kind_w;
	nmld_pkg::nmld_kind_t  fkind_q;
	nmld_pkg::nmld_nib_t   wr_file_q [16];
	nmld_pkg::nmld_nib_t   acc_q;
	nmld_pkg::nmld_nib_t   move_w;
	logic                  zf_q;
	logic                  take_w;
	logic [6:0]            faddr_q;
	logic [3:0]            fwr_q;
	logic [15:0]           rom_addr_q;
	logic                  we_q;
	logic [6:0]            waddr_q;
	logic [3:0]            wdata_q;
	logic [3:0]            chg_flags_w;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Sorts an instruction word into one of the moves this block owns.
	function automatic nmld_pkg::nmld_kind_t decode(input logic [15:0] ins);
		if (ins[15:7] == `NMLD_OP9_COPY_BANK)
			return nmld_pkg::NMLD_K_BANK;
		else if (ins[15:7] == `NMLD_OP9_COPY_CHG)
			return nmld_pkg::NMLD_K_CHG;
		else if (ins[15:7] == `NMLD_OP9_FETCH_PTR)
			return nmld_pkg::NMLD_K_FPTR;
		else if (ins[15:11] == `NMLD_OP5_WR_TO_MEM)
			return nmld_pkg::NMLD_K_WR2M;
		else if (ins[15:11] == `NMLD_OP5_MEM_TO_WR)
			return nmld_pkg::NMLD_K_M2WR;
		else if (ins[15:11] == `NMLD_OP5_FETCH_IMM)
			return nmld_pkg::NMLD_K_FIMM;
		else
			return nmld_pkg::NMLD_K_NONE;
	endfunction

	// Zero test shared by every flag-updating move.
	function automatic logic is_zero(input logic [3:0] v);
		return (v == 4'h0);
	endfunction

	// ****************************************************************
	// Change detect and hold cause
	// ****************************************************************
	nmld_change_detect u_chg (
		.clk         (CLK),
		.reset_n     (RESET_N),
		.ce          (CE),
		.wake        (WAKE_PORT),
		.flags_clr   (take_w && (kind_w == nmld_pkg::NMLD_K_CHG)),
		.hold_active (HOLD_ACTIVE),
		.cause_clr   (CAUSE_CLR),
		.flags       (chg_flags_w),
		.cause       (HOLD_RELEASE_CAUSE)
	);

	// ****************************************************************
	// Decode and source selection
	// ****************************************************************

	// New words are accepted only when idle; a fetch in flight stalls the core.
	assign kind_w = decode(INSTR);
	assign take_w = CE && INSTR_VALID && (state_q == nmld_pkg::NMLD_IDLE);
	assign BUSY   = (state_q == nmld_pkg::NMLD_FETCH);

	// Memory read address always follows the operand field of the offered word.
	assign RAM_RADDR = INSTR[6:0];

	// The nibble each one-cycle move carries.
	always_comb
	begin
		move_w = 4'h0;
		case (kind_w)
			nmld_pkg::NMLD_K_BANK: move_w = BANK_SELECT;
			nmld_pkg::NMLD_K_CHG:  move_w = chg_flags_w;
			nmld_pkg::NMLD_K_WR2M: move_w = wr_file_q[INSTR[10:7]];
			nmld_pkg::NMLD_K_M2WR: move_w = RAM_RDATA;
			default:               move_w = 4'h0;
		endcase
	end

	// ****************************************************************
	// Sequencer for the two-cycle table fetches
	// ****************************************************************
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			state_q <= nmld_pkg::NMLD_IDLE;
		else if (CE)
		begin
			case (state_q)
				nmld_pkg::NMLD_IDLE:
					if (take_w && ((kind_w == nmld_pkg::NMLD_K_FPTR) ||
						(kind_w == nmld_pkg::NMLD_K_FIMM)))
						state_q <= nmld_pkg::NMLD_FETCH;
				default:
					state_q <= nmld_pkg::NMLD_IDLE;
			endcase
		end
	end

	// Fetch address and destination are latched in the first cycle.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rom_addr_q <= 16'h0000;
			faddr_q    <= 7'h00;
			fwr_q      <= 4'h0;
			fkind_q    <= nmld_pkg::NMLD_K_NONE;
		end
		else if (CE && take_w)
		begin
			fkind_q <= kind_w;
			faddr_q <= INSTR[6:0];
			fwr_q   <= INSTR[10:7];
			if (kind_w == nmld_pkg::NMLD_K_FPTR)
				rom_addr_q <= {LOOKUP_PTR_HIGH, 4'h0, LOOKUP_PTR_LOW, acc_q};
			else if (kind_w == nmld_pkg::NMLD_K_FIMM)
				rom_addr_q <= {5'h00, INSTR[6:0], acc_q};
		end
	end

	assign ROM_ADDR = rom_addr_q;

	// ****************************************************************
	// Accumulator and zero flag
	// ****************************************************************

	// Table fetches leave both untouched; every other move here updates them.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			acc_q <= `NMLD_NIB_RESET;
			zf_q  <= 1'b0;
		end
		else if (take_w && (kind_w != nmld_pkg::NMLD_K_NONE) &&
			(kind_w != nmld_pkg::NMLD_K_FPTR) && (kind_w != nmld_pkg::NMLD_K_FIMM))
		begin
			acc_q <= move_w;
			zf_q  <= is_zero(move_w);
		end
	end

	assign WORKING_SUM      = acc_q;
	assign RESULT_ZERO_FLAG = zf_q;
	assign PORT_C_CHANGE_FLAGS = chg_flags_w;

	// ****************************************************************
	// Working register file
	// ****************************************************************
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < 16; i++)
				wr_file_q[i] <= `NMLD_NIB_RESET;
		end
		else if (CE)
		begin
			if (take_w && (kind_w == nmld_pkg::NMLD_K_M2WR))
				wr_file_q[INSTR[10:7]] <= RAM_RDATA;
			else if (BUSY && (fkind_q == nmld_pkg::NMLD_K_FIMM))
				wr_file_q[fwr_q] <= ROM_DATA;
		end
	end

	// ****************************************************************
	// Data memory write port
	// ****************************************************************

	// Writes are registered, so memory sees them one edge after the move.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			we_q    <= 1'b0;
			waddr_q <= 7'h00;
			wdata_q <= 4'h0;
		end
		else if (CE)
		begin
			we_q <= 1'b0;
			if (take_w && ((kind_w == nmld_pkg::NMLD_K_BANK) ||
				(kind_w == nmld_pkg::NMLD_K_CHG) || (kind_w == nmld_pkg::NMLD_K_WR2M)))
			begin
				we_q    <= 1'b1;
				waddr_q <= INSTR[6:0];
				wdata_q <= move_w;
			end
			else if (BUSY && (fkind_q == nmld_pkg::NMLD_K_FPTR))
			begin
				we_q    <= 1'b1;
				waddr_q <= faddr_q;
				wdata_q <= ROM_DATA;
			end
		end
	end

	assign RAM_WE    = we_q;
	assign RAM_WADDR = waddr_q;
	assign RAM_WDATA = wdata_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_BANK_COPY: assert property (@(posedge CLK) disable iff (!RESET_N)
		(take_w && kind_w == nmld_pkg::NMLD_K_BANK) |=>
		(RAM_WE && RAM_WDATA == $past(BANK_SELECT) && acc_q == $past(BANK_SELECT)
		&& RAM_WADDR == $past(INSTR[6:0])))
		else $error("Bank select copy wrong.");
	AST_CHG_COPY: assert property (@(posedge CLK) disable iff (!RESET_N)
		(take_w && kind_w == nmld_pkg::NMLD_K_CHG) |=>
		(RAM_WE && acc_q == $past(chg_flags_w) && RAM_WDATA == acc_q))
		else $error("Change flag copy wrong.");
	AST_WR_TO_MEM: assert property (@(posedge CLK) disable iff (!RESET_N)
		(take_w && kind_w == nmld_pkg::NMLD_K_WR2M) |=>
		(RAM_WE && RAM_WDATA == acc_q && acc_q == wr_file_q[$past(INSTR[10:7])]))
		else $error("Register to memory copy wrong.");
	AST_MEM_TO_WR: assert property (@(posedge CLK) disable iff (!RESET_N)
		(take_w && kind_w == nmld_pkg::NMLD_K_M2WR) |=>
		(!RAM_WE && acc_q == $past(RAM_RDATA) && wr_file_q[$past(INSTR[10:7])] == acc_q))
		else $error("Memory to register copy wrong.");
	AST_PTR_FETCH: assert property (@(posedge CLK) disable iff (!RESET_N)
		(take_w && kind_w == nmld_pkg::NMLD_K_FPTR) |=> BUSY ##1
		(!BUSY && RAM_WE && RAM_WADDR == $past(faddr_q) && RAM_WDATA == $past(ROM_DATA)))
		else $error("Pointer fetch sequence wrong.");
	AST_PTR_ADDR: assert property (@(posedge CLK) disable iff (!RESET_N)
		(take_w && kind_w == nmld_pkg::NMLD_K_FPTR) |=>
		(ROM_ADDR == {$past(LOOKUP_PTR_HIGH), 4'h0,
		$past(LOOKUP_PTR_LOW), $past(acc_q)}))
		else $error("Pointer fetch address wrong.");
	AST_IMM_FETCH: assert property (@(posedge CLK) disable iff (!RESET_N)
		(take_w && kind_w == nmld_pkg::NMLD_K_FIMM) |=>
		(BUSY && ROM_ADDR == {5'h00, $past(INSTR[6:0]), $past(acc_q)}) ##1
		(!BUSY && wr_file_q[fwr_q] == $past(ROM_DATA)))
		else $error("Immediate fetch wrong.");
	AST_ZERO_FLAG: assert property (@(posedge CLK) disable iff (!RESET_N)
		$changed(acc_q) |-> (zf_q == (acc_q == 4'h0)))
		else $error("Zero flag does not match accumulator.");
endmodule

// *** testbench/test_nibble_move_lookup_decode.sv ***
`timescale 1ns/100ps
`include "nmld_cfg.svh"
module test_nibble_move_lookup_decode;
	// ****************************************************************
	// Signals and device under test
	// ****************************************************************
	logic        clk, rst_n, ce, ivalid, busy, hold, cclr, we, zf;
	logic [15:0] instr, rom_addr, a;
	logic [3:0]  bank, ptr_l, ptr_h, wake, cause, flags, wdata, acc, rom_data, v, d;
	logic [6:0]  raddr, waddr, r, imm;
	logic [3:0]  ram [128];
	logic [11:0] wq [$];
	logic [11:0] exp_w;
	int          fails, total_checks, cyc;

	nmld_top dut (.CLK(clk), .RESET_N(rst_n), .CE(ce), .INSTR_VALID(ivalid), .INSTR(instr),
		.BUSY(busy), .BANK_SELECT(bank), .LOOKUP_PTR_LOW(ptr_l), .LOOKUP_PTR_HIGH(ptr_h),
		.WAKE_PORT(wake), .HOLD_ACTIVE(hold), .CAUSE_CLR(cclr), .HOLD_RELEASE_CAUSE(cause),
		.PORT_C_CHANGE_FLAGS(flags), .RAM_RADDR(raddr), .RAM_RDATA(ram[raddr]), .RAM_WE(we),
		.RAM_WADDR(waddr), .RAM_WDATA(wdata), .ROM_ADDR(rom_addr), .ROM_DATA(rom_data),
		.WORKING_SUM(acc), .RESULT_ZERO_FLAG(zf));

	// The table contents mix every address nibble, so a wrong address shows as wrong data.
	function automatic logic [3:0] rom_f(input logic [15:0] x);
		return x[3:0] ^ x[7:4] ^ x[11:8] ^ x[15:12] ^ 4'h9;
	endfunction
	assign rom_data = rom_f(rom_addr);

	// The data memory model takes every write the block issues.
	always @(posedge clk)
	begin
		if (we)
			ram[waddr] <= wdata;
	end

	always #10 clk = ~clk;

	// ****************************************************************
	// Compare and closing tasks
	// ****************************************************************
	task automatic chk_val(input string what, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_acc(input logic [3:0] e);
		chk_val("sum", acc, e);
		chk_val("zero flag", zf, e == 4'h0);
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// The watcher pops the oldest expected write whenever a write pulse is seen.
	always @(negedge clk)
	begin
		cyc++;
		if (rst_n && we)
		begin
			exp_w = wq.size() ? wq.pop_front() : 12'h000;
			chk_val("write", {1'b1, waddr, wdata}, exp_w);
		end
		if (cyc > 3000)
		begin
			fails++;
			end_of_test();
		end
	end

	// ****************************************************************
	// Drivers
	// ****************************************************************
	// A kept request leaves the valid line high so the next one follows back to back.
	task automatic op(input logic [15:0] i, input bit keep);
		instr <= i;
		ivalid <= 1'b1;
		@(posedge clk);
		if (!keep)
			ivalid <= 1'b0;
	endtask

	task automatic mv(input logic [15:0] i, input logic [3:0] e);
		op(i, 0);
		@(negedge clk);
		chk_acc(e);
		@(posedge clk);
	endtask

	task automatic bank_copy(input logic [6:0] ad, input logic [3:0] val);
		bank <= val;
		wq.push_back({1'b1, ad, val});
		mv({`NMLD_OP9_COPY_BANK, ad}, val);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(32'h87cc));
		{clk, rst_n, ivalid, hold, cclr} = 5'h00;
		ce = 1'b1;
		{instr, bank, ptr_l, ptr_h, wake} = 32'h0000_0000;
		foreach (ram[k]) ram[k] = 4'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Bank copies, the first one with a zero value to set the flag.
		for (int n = 0; n < 6; n++)
			bank_copy(7'($urandom), (n == 0) ? 4'h0 : 4'($urandom));
		// Load each working register from memory, then copy it back out at once.
		for (int w = 0; w < 16; w++)
		begin
			v = 4'($urandom);
			ram[7'(w + 16)] <= v;
			op({`NMLD_OP5_MEM_TO_WR, 4'(w), 7'(w + 16)}, 1);
			wq.push_back({1'b1, 7'(w + 64), v});
			mv({`NMLD_OP5_WR_TO_MEM, 4'(w), 7'(w + 64)}, v);
		end
		mv({`NMLD_OP5_MEM_TO_WR, 4'h3, 7'h13}, ram[7'h13]);
		// Change flags follow the wake pins and clear once they are read.
		wake <= 4'h5;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk_val("flags", flags, 4'h5);
		chk_val("cause", cause, 4'h0);
		@(posedge clk);
		wq.push_back({1'b1, 7'h11, 4'h5});
		mv({`NMLD_OP9_COPY_CHG, 7'h11}, 4'h5);
		wq.push_back({1'b1, 7'h12, 4'h0});
		mv({`NMLD_OP9_COPY_CHG, 7'h12}, 4'h0);
		// A pin change while holding marks the wake cause bit.
		hold <= 1'b1;
		wake <= 4'hA;
		repeat (3) @(posedge clk);
		hold <= 1'b0;
		@(negedge clk);
		chk_val("cause", cause, 4'h4);
		chk_val("flags", flags, 4'hF);
		@(posedge clk);
		cclr <= 1'b1;
		@(posedge clk);
		cclr <= 1'b0;
		@(negedge clk);
		chk_val("cause", cause, 4'h0);
		@(posedge clk);
		// Table fetches; a request offered while busy must be ignored.
		for (int n = 0; n < 4; n++)
		begin
			v = 4'($urandom);
			bank_copy(7'h20, v);
			ptr_h <= 4'($urandom);
			ptr_l <= 4'($urandom);
			r = 7'($urandom);
			@(posedge clk);
			op({`NMLD_OP9_FETCH_PTR, r}, 1);
			instr <= {`NMLD_OP9_COPY_BANK, 7'h7F};
			a = {ptr_h, 4'h0, ptr_l, v};
			wq.push_back({1'b1, r, rom_f(a)});
			@(negedge clk);
			chk_val("busy", busy, 1'b1);
			chk_val("rom address", rom_addr, a);
			@(posedge clk);
			ivalid <= 1'b0;
			@(negedge clk);
			chk_val("busy", busy, 1'b0);
			chk_acc(v);
			@(posedge clk);
			imm = 7'($urandom);
			op({`NMLD_OP5_FETCH_IMM, 4'(n + 5), imm}, 0);
			a = {5'h00, imm, v};
			d = rom_f(a);
			@(negedge clk);
			chk_val("busy", busy, 1'b1);
			chk_val("rom address", rom_addr, a);
			@(posedge clk);
			wq.push_back({1'b1, 7'(n + 48), d});
			mv({`NMLD_OP5_WR_TO_MEM, 4'(n + 5), 7'(n + 48)}, d);
		end
		// With the clock enable low a request must leave everything untouched.
		ce <= 1'b0;
		bank <= 4'h9;
		op({`NMLD_OP9_COPY_BANK, 7'h01}, 0);
		@(negedge clk);
		chk_acc(d);
		@(posedge clk);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk_val("pending writes", 16'(wq.size()), 16'h0000);
		end_of_test();
	end
endmodule
